// ### ecpfm_top.sv
// ECP port control: shared byte queue, register views, mode control and line engines
`timescale 1ns/10ps
`default_nettype none
module ecpfm_top #(
    parameter int DEPTH = ecpfm_pkg::QUEUE_DEPTH,
    parameter int CW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [10:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic dma_req,
    input wire logic dma_ack,
    input wire logic dma_tc,
    output logic service_irq,
    output logic fault_irq,
    input wire logic irq_line_level,
    input wire logic epp_option,
    output logic epp_active,
    input wire logic [CW:0] forward_free_threshold,
    input wire logic [CW:0] reverse_fill_threshold,
    input wire logic [7:0] pd_in,
    output logic [7:0] pd_out,
    output logic pd_oe,
    input wire ecpfm_pkg::ecpfm_pins_in_s pins_in,
    output ecpfm_pkg::ecpfm_pins_out_s pins_out
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_TX_WAIT, ST_TX_STB, ST_TX_REL, ST_RX_REQ, ST_RX_DONE
    } ecpfm_state_e;

    // Reset release through two flops; assertion stays asynchronous
    logic rst_a_q, rst_b_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end
    wire logic rst_s_n = rst_b_q;

    // Pins from the peripheral and the interrupt line pass two flops
    logic [7:0] pd_m_q, pd_s_q;
    ecpfm_pkg::ecpfm_pins_in_s pin_m_q, pin_s_q;
    logic lvl_m_q, lvl_s_q;
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pd_m_q <= 8'h00;
            pd_s_q <= 8'h00;
            pin_m_q <= 5'h09; // Idle levels: ack and fault high, so reset leaves no false edge
            pin_s_q <= 5'h09;
            lvl_m_q <= 1'b0;
            lvl_s_q <= 1'b0;
        end else begin
            pd_m_q <= pd_in;
            pd_s_q <= pd_m_q;
            pin_m_q <= pins_in;
            pin_s_q <= pin_m_q;
            lvl_m_q <= irq_line_level;
            lvl_s_q <= lvl_m_q;
        end
    end

    // Register state
    logic [7:0] data_q;
    logic [5:0] dcr_q;
    logic [2:0] mode_q;
    logic fault_dis_q, dma_en_q, service_q;
    logic [2:0] capb_irq_q;
    logic fault_n_prev_q;
    logic service_irq_q, fault_irq_q;
    logic [7:0] rdata_q;

    // Queue storage: byte plus a tag that is set for data and clear for commands
    logic [8:0] mem_q [DEPTH];
    logic [CW-1:0] wp_q, rp_q;
    logic [CW:0] cnt_q;

    // Line engine
    ecpfm_state_e st_q;
    logic [7:0] tx_byte_q;
    logic tx_tag_q;
    logic [$clog2(ecpfm_pkg::STROBE_CYCLES + 1)-1:0] stb_cnt_q;

    // Mode and direction decode
    wire logic mode_std = (mode_q == ecpfm_pkg::MODE_STD);
    wire logic mode_bidir = (mode_q == ecpfm_pkg::MODE_BIDIR);
    wire logic mode_pfifo = (mode_q == ecpfm_pkg::MODE_PFIFO);
    wire logic mode_ecp = (mode_q == ecpfm_pkg::MODE_ECP);
    wire logic mode_test = (mode_q == ecpfm_pkg::MODE_TEST);
    wire logic mode_cfg = (mode_q == ecpfm_pkg::MODE_CONFIG);
    wire logic dir_rev = dcr_q[ecpfm_pkg::DCR_DIR] && !mode_std && !mode_pfifo;
    wire logic queue_mode = mode_pfifo || mode_ecp || mode_test;

    // Queue flags
    wire logic q_full = (cnt_q == (CW + 1)'(DEPTH));
    wire logic q_empty = (cnt_q == '0);
    wire logic [CW:0] q_free = (CW + 1)'(DEPTH) - cnt_q;

    // Host access decode; a DMA acknowledge steers the strobe to the queue
    wire logic hit_data = !dma_ack && (io_addr == ecpfm_pkg::OFS_DATA);
    wire logic hit_queue = dma_ack || (io_addr == ecpfm_pkg::OFS_QUEUE);
    wire logic hit_ctrl = !dma_ack && (io_addr == ecpfm_pkg::OFS_CONTROL);
    wire logic hit_capb = !dma_ack && (io_addr == ecpfm_pkg::OFS_CAP_B);
    wire logic hit_ecr = !dma_ack && (io_addr == ecpfm_pkg::OFS_EXT_CTRL);

    // Pushes from the host side: FIFO mode, ECP data, ECP address, test queue
    wire logic fwd_q_mode = (mode_pfifo && !dir_rev) || (mode_ecp && !dir_rev);
    wire logic wr_dq = io_wr && hit_queue && (fwd_q_mode || mode_test);
    wire logic wr_aq = io_wr && hit_data && mode_ecp && !dir_rev;
    wire logic host_push = (wr_dq || wr_aq) && !q_full;
    wire logic [8:0] host_item = {wr_dq, io_wdata};
    wire logic host_pop = io_rd && hit_queue && !q_empty && ((mode_ecp && dir_rev) || mode_test);

    // Pushes and pops from the line engine
    wire logic rx_push = (st_q == ST_RX_REQ) && !pin_s_q.ack_n && !q_full;
    wire logic tx_pop = (st_q == ST_IDLE) && fwd_q_mode && !q_empty && !pin_s_q.busy;
    wire logic push = host_push || rx_push;
    wire logic pop = host_pop || tx_pop;
    wire logic [8:0] push_item = rx_push ? {1'b1, pd_s_q} : host_item;

    // Mode writes: standard or bidirectional may change to any mode, the others only to standard or bidirectional
    wire logic [2:0] new_mode = io_wdata[7:5];
    wire logic leave_ok = mode_std || mode_bidir
                          || new_mode == ecpfm_pkg::MODE_STD || new_mode == ecpfm_pkg::MODE_BIDIR;
    wire logic ecr_wr = io_wr && hit_ecr;

    // Service events; level conditions re-arm themselves as long as they hold
    wire logic svc_event = dma_en_q ? (dma_tc && dma_ack)
                         : (queue_mode && (dir_rev ? (cnt_q >= reverse_fill_threshold)
                                                   : (q_free >= forward_free_threshold)));
    wire logic svc_set = svc_event && !service_q && queue_mode;

    // Fault interrupt: falling edge, or clearing the disable while fault is low
    wire logic fault_fall = fault_n_prev_q && !pin_s_q.peripheral_fault_n;
    wire logic dis_clear = ecr_wr && fault_dis_q && !io_wdata[ecpfm_pkg::ECR_FAULT_DIS];
    wire logic fault_evt = mode_ecp && ((!fault_dis_q && fault_fall)
                           || (dis_clear && !pin_s_q.peripheral_fault_n));

    // Register read multiplexer
    wire logic [7:0] status_view = {~pin_s_q.busy, pin_s_q.ack_n, pin_s_q.perror, pin_s_q.select,
                                    pin_s_q.peripheral_fault_n, 3'h7};
    wire logic [7:0] ctrl_view = {2'h3, dcr_q};
    wire logic [7:0] capb_view = {1'b0, lvl_s_q, capb_irq_q, 3'h7};
    wire logic [7:0] ecr_view = {mode_q, fault_dis_q, dma_en_q, service_q, q_full, q_empty};
    wire logic [7:0] data_view = mode_bidir ? pd_s_q : data_q;
    wire logic [7:0] head_byte = mem_q[rp_q][7:0];
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (hit_ecr) begin
            rd_mux = ecr_view;
        end else if (hit_ctrl) begin
            rd_mux = ctrl_view;
        end else if (io_addr == ecpfm_pkg::OFS_STATUS && !dma_ack) begin
            rd_mux = status_view;
        end else if (hit_data && (mode_std || mode_bidir)) begin
            rd_mux = data_view;
        end else if (hit_queue && mode_cfg && !dma_ack) begin
            rd_mux = ecpfm_pkg::CAP_A_VALUE;
        end else if (hit_capb && mode_cfg) begin
            rd_mux = capb_view;
        end else if (host_pop) begin
            rd_mux = head_byte;
        end
    end

    // Read data held after each read strobe
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rdata_q <= 8'h00;
        end else if (io_rd) begin
            rdata_q <= rd_mux;
        end
    end

    // Control registers written by the host
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            data_q <= ecpfm_pkg::DATA_RESET;
            dcr_q <= ecpfm_pkg::DCR_RESET;
            mode_q <= ecpfm_pkg::ECR_MODE_RESET;
            fault_dis_q <= ecpfm_pkg::ECR_FAULT_DIS_RESET;
            dma_en_q <= ecpfm_pkg::ECR_DMA_EN_RESET;
            capb_irq_q <= ecpfm_pkg::CAPB_IRQ_RESET;
        end else begin
            if (io_wr && hit_data && (mode_std || mode_bidir)) begin
                data_q <= io_wdata;
            end
            if (io_wr && hit_ctrl) begin
                dcr_q[4:0] <= io_wdata[4:0];
                if (mode_bidir) begin
                    dcr_q[ecpfm_pkg::DCR_DIR] <= io_wdata[ecpfm_pkg::DCR_DIR];
                end
            end
            if (io_wr && hit_capb && mode_cfg) begin
                capb_irq_q <= io_wdata[5:3];
            end
            if (ecr_wr) begin
                if (leave_ok) begin
                    mode_q <= new_mode;
                end
                fault_dis_q <= io_wdata[ecpfm_pkg::ECR_FAULT_DIS];
                dma_en_q <= io_wdata[ecpfm_pkg::ECR_DMA_EN];
            end
        end
    end

    // Service bit: a hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            service_q <= ecpfm_pkg::ECR_SERVICE_RESET;
        end else if (svc_set) begin
            service_q <= 1'b1;
        end else if (ecr_wr) begin
            service_q <= io_wdata[ecpfm_pkg::ECR_SERVICE];
        end
    end

    // Interrupt pulses; a software write of one never produces one
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            fault_n_prev_q <= 1'b1;
            service_irq_q <= 1'b0;
            fault_irq_q <= 1'b0;
        end else begin
            fault_n_prev_q <= pin_s_q.peripheral_fault_n;
            service_irq_q <= svc_set;
            fault_irq_q <= fault_evt;
        end
    end

    // Shared queue; standard mode holds it empty
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else if (mode_std) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Queue storage has no reset; only written slots are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= push_item;
        end
    end

    // Line engine: forward strobe cycles and reverse request cycles
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            st_q <= ST_IDLE;
            tx_byte_q <= 8'h00;
            tx_tag_q <= 1'b1;
            stb_cnt_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (tx_pop) begin
                        tx_byte_q <= head_byte;
                        tx_tag_q <= mem_q[rp_q][8];
                        st_q <= ST_TX_WAIT;
                    end else if (mode_ecp && dir_rev) begin
                        st_q <= ST_RX_REQ;
                    end
                end
                ST_TX_WAIT: begin
                    stb_cnt_q <= '0;
                    st_q <= ST_TX_STB; // Setup cycle before the strobe falls
                end
                ST_TX_STB: begin
                    stb_cnt_q <= stb_cnt_q + 1'b1;
                    if (mode_ecp ? pin_s_q.busy
                                 : (stb_cnt_q == ($bits(stb_cnt_q))'(ecpfm_pkg::STROBE_CYCLES - 1))) begin
                        st_q <= ST_TX_REL;
                    end
                end
                ST_TX_REL: begin
                    if (mode_ecp ? !pin_s_q.busy : 1'b1) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_RX_REQ: begin
                    if (rx_push) begin
                        st_q <= ST_RX_DONE;
                    end else if (!(mode_ecp && dir_rev)) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_RX_DONE: begin
                    if (pin_s_q.ack_n) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Engine-owned lines; in other modes the control register drives the pins
    wire logic eng_strobe = (st_q == ST_TX_STB);
    wire logic eng_rx_req = (st_q == ST_RX_REQ);
    wire logic engine_mode = mode_pfifo || mode_ecp;
    always_comb begin
        pins_out.strobe_n = ~dcr_q[ecpfm_pkg::DCR_STROBE];
        pins_out.autofd_n = ~dcr_q[ecpfm_pkg::DCR_AUTOFD];
        pins_out.init_n = dcr_q[ecpfm_pkg::DCR_INIT];
        pins_out.selin_n = ~dcr_q[ecpfm_pkg::DCR_SELIN];
        if (engine_mode) begin
            pins_out.strobe_n = ~eng_strobe;
        end
        if (mode_ecp) begin
            pins_out.autofd_n = dir_rev ? ~eng_rx_req : tx_tag_q;
            pins_out.init_n = ~dir_rev;
        end
    end

    // Data lines: the queue byte in engine modes, the latch elsewhere; test-mode queue data never shows
    assign pd_out = engine_mode ? tx_byte_q : data_q;
    assign pd_oe = !dir_rev;

    // DMA is requested only when enabled and not blocked by the service bit
    wire logic dma_room = dir_rev ? !q_empty : !q_full;
    assign dma_req = dma_en_q && !service_q && queue_mode && dma_room;

    // Mode 100 enables EPP only with the option; 101 does nothing
    assign epp_active = (mode_q == ecpfm_pkg::MODE_EPP) && epp_option;

    assign io_rdata = rdata_q;
    assign service_irq = service_irq_q;
    assign fault_irq = fault_irq_q;
endmodule
`default_nettype wire

// ### ecpfm_pkg.sv
// Package with register offsets, mode codes, field positions and pin carriers for the ECP port control
package ecpfm_pkg;
    // Register offsets relative to the port base
    localparam logic [10:0] OFS_DATA = 11'h000;
    localparam logic [10:0] OFS_STATUS = 11'h001;
    localparam logic [10:0] OFS_CONTROL = 11'h002;
    localparam logic [10:0] OFS_QUEUE = 11'h400;
    localparam logic [10:0] OFS_CAP_B = 11'h401;
    localparam logic [10:0] OFS_EXT_CTRL = 11'h402;

    // Port mode codes held in the top three bits of extended_control
    localparam logic [2:0] MODE_STD = 3'h0;
    localparam logic [2:0] MODE_BIDIR = 3'h1;
    localparam logic [2:0] MODE_PFIFO = 3'h2;
    localparam logic [2:0] MODE_ECP = 3'h3;
    localparam logic [2:0] MODE_EPP = 3'h4;
    localparam logic [2:0] MODE_TEST = 3'h6;
    localparam logic [2:0] MODE_CONFIG = 3'h7;

    // Field positions of extended_control
    localparam int ECR_MODE_LSB = 5;
    localparam int ECR_FAULT_DIS = 4;
    localparam int ECR_DMA_EN = 3;
    localparam int ECR_SERVICE = 2;
    // Field positions of printer_control
    localparam int DCR_DIR = 5;
    localparam int DCR_ACK_IEN = 4;
    localparam int DCR_SELIN = 3;
    localparam int DCR_INIT = 2;
    localparam int DCR_AUTOFD = 1;
    localparam int DCR_STROBE = 0;
    // Field positions of capability_b
    localparam int CAPB_LEVEL = 6;
    localparam int CAPB_IRQ_LSB = 3;

    // Fixed and reset values
    localparam logic [7:0] CAP_A_VALUE = 8'h10;
    localparam logic [2:0] CAPB_IRQ_RESET = 3'h0;
    localparam logic [2:0] ECR_MODE_RESET = 3'h0;
    localparam logic ECR_FAULT_DIS_RESET = 1'b1;
    localparam logic ECR_DMA_EN_RESET = 1'b0;
    localparam logic ECR_SERVICE_RESET = 1'b1;
    localparam logic [5:0] DCR_RESET = 6'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Queue shape
    localparam int QUEUE_DEPTH = 16;

    // Compatibility strobe width
    localparam int CLK_PERIOD_NS = 40;
    localparam int STROBE_WIDTH_NS = 500;
    localparam int STROBE_CYCLES = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Peripheral inputs, raw at the port and after synchronisation
    typedef struct packed {
        logic busy;
        logic ack_n;
        logic perror;
        logic select;
        logic peripheral_fault_n;
    } ecpfm_pins_in_s;

    // Peripheral control outputs
    typedef struct packed {
        logic strobe_n;
        logic autofd_n;
        logic init_n;
        logic selin_n;
    } ecpfm_pins_out_s;
endpackage

// ### ecpfm_asserts.sv
// Port-level assertions for the ECP port control block
`timescale 1ns/10ps
`default_nettype none
module ecpfm_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dma_req,
    input wire logic dma_ack,
    input wire logic dma_tc,
    input wire logic service_irq,
    input wire logic fault_irq,
    input wire logic epp_option,
    input wire logic epp_active,
    input wire logic [7:0] pd_out,
    input wire ecpfm_pkg::ecpfm_pins_in_s pins_in,
    input wire ecpfm_pkg::ecpfm_pins_out_s pins_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Steps of one forward strobe: it falls, then stays low a while
    sequence s_strobe_fall;
        $fell(pins_out.strobe_n);
    endsequence
    sequence s_strobe_held;
        !pins_out.strobe_n && !$past(pins_out.strobe_n);
    endsequence

    chk_epp_gate: assert property (epp_active |-> epp_option)
        else $error("epp active without option");
    chk_svc_single: assert property (service_irq |=> !service_irq)
        else $error("service pulse longer than one cycle");
    chk_svc_blocks: assert property (service_irq |-> !dma_req)
        else $error("dma request while service bit set");
    chk_tc_service: assert property (dma_ack && dma_tc && dma_req |-> ##[1:2] service_irq)
        else $error("terminal count gave no service pulse");
    chk_fault_cause: assert property (fault_irq |-> !pins_in.peripheral_fault_n)
        else $error("fault pulse without fault input low");
    chk_strobe_end: assert property (s_strobe_fall |-> ##[1:60] pins_out.strobe_n)
        else $error("strobe never released");
    chk_data_steady: assert property (s_strobe_held |-> $stable(pd_out))
        else $error("data changed under strobe");
    chk_tag_steady: assert property (s_strobe_held |-> $stable(pins_out.autofd_n))
        else $error("tag changed under strobe");
endmodule
`default_nettype wire

// ### ecpfm_periph.sv
// Peripheral model: answers forward strobes with busy and sends reverse bytes
`timescale 1ns/10ps
`default_nettype none
module ecpfm_periph (
    input wire logic clk,
    input wire logic [7:0] pd_out,
    input wire logic pd_oe,
    input wire logic fault_n,
    input wire ecpfm_pkg::ecpfm_pins_out_s pins_out,
    output logic [7:0] pd_in,
    output ecpfm_pkg::ecpfm_pins_in_s pins_in
);
    int dly = 0;
    logic busy = 1'b0;
    logic ack_n = 1'b1;
    logic [7:0] drv = 8'h00;
    logic [8:0] rx_q[$];
    logic [7:0] tx_q[$];

    // Wire level: the port wins while it drives, else our own bus
    assign pd_in = pd_oe ? pd_out : drv;
    assign pins_in = {busy, ack_n, 1'b1, 1'b1, fault_n};

    // One transfer at a time; dly makes the peripheral stall
    initial begin
        forever begin
            @(posedge clk);
            if (pd_oe && !pins_out.strobe_n) begin
                repeat (dly) @(posedge clk);
                #1 busy = 1'b1;
                rx_q.push_back({pins_out.autofd_n, pd_out});
                while (!pins_out.strobe_n) @(posedge clk);
                repeat (dly) @(posedge clk);
                #1 busy = 1'b0;
            end else if (!pd_oe && !pins_out.init_n && !pins_out.autofd_n && tx_q.size() > 0) begin
                #1 drv = tx_q.pop_front();
                busy = 1'b1;
                @(posedge clk);
                #1 ack_n = 1'b0;
                while (!pins_out.autofd_n) @(posedge clk);
                #1 ack_n = 1'b1;
                busy = 1'b0;
                drv = ~drv; // Hold over: never leave the old byte
            end
        end
    end
endmodule
`default_nettype wire

// ### ecp_fifo_mode_control_tb.sv
// Self-checking bench for the ECP port control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module ecp_fifo_mode_control_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [10:0] io_addr = 11'h000;
    logic io_rd = 1'b0;
    logic io_wr = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic dma_req;
    logic dma_ack = 1'b0;
    logic dma_tc = 1'b0;
    logic service_irq;
    logic fault_irq;
    logic lvl = 1'b0;
    logic epp_option = 1'b0;
    logic epp_active;
    logic [7:0] pd_in;
    logic [7:0] pd_out;
    logic pd_oe;
    logic fault_n = 1'b1;
    ecpfm_pkg::ecpfm_pins_in_s pins_in;
    ecpfm_pkg::ecpfm_pins_out_s pins_out;
    int fails = 0;
    int check_count = 0;
    int svc_n = 0;
    int flt_n = 0;
    int k;
    logic [7:0] r;
    // Rows: write flag, offset, write data, expected read
    logic [27:0] rows [13] = '{{1'b0, 11'h402, 16'h0015}, {1'b0, 11'h002, 16'h00C0},
        {1'b1, 11'h002, 16'h2000}, {1'b0, 11'h002, 16'h00C0}, {1'b1, 11'h000, 16'hA500},
        {1'b0, 11'h000, 16'h00A5}, {1'b0, 11'h003, 16'h0000}, {1'b1, 11'h402, 16'hF400},
        {1'b0, 11'h400, 16'h0010}, {1'b1, 11'h400, 16'hFF00}, {1'b0, 11'h400, 16'h0010},
        {1'b1, 11'h402, 16'hD400}, {1'b0, 11'h402, 16'h00F5}};

    always #20 clk = ~clk;

    // Count interrupt pulses as they pass
    always @(posedge clk) begin
        if (service_irq === 1'b1) svc_n++;
        if (fault_irq === 1'b1) flt_n++;
    end

    ecpfm_top u_dut (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .dma_req(dma_req), .dma_ack(dma_ack), .dma_tc(dma_tc),
        .service_irq(service_irq), .fault_irq(fault_irq), .irq_line_level(lvl), .epp_option(epp_option),
        .epp_active(epp_active), .forward_free_threshold(5'h08), .reverse_fill_threshold(5'h03),
        .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pins_in(pins_in), .pins_out(pins_out));

    ecpfm_periph u_prn (.clk(clk), .pd_out(pd_out), .pd_oe(pd_oe), .fault_n(fault_n),
        .pins_out(pins_out), .pd_in(pd_in), .pins_in(pins_in));

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk);
        #1 io_wr = 1'b0;
    endtask

    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 io_addr = a;
        io_rd = 1'b1;
        @(posedge clk);
        #1 io_rd = 1'b0;
        d = io_rdata;
    endtask

    // DMA write: ack once a request is up, or after 100 cycles without one
    task automatic dma(input logic [7:0] d, input logic last);
        @(posedge clk);
        #1;
        for (int t = 0; t < 100 && dma_req !== 1'b1; t++) @(posedge clk) #1;
        dma_ack = 1'b1;
        io_wr = 1'b1;
        io_wdata = d;
        dma_tc = last;
        @(posedge clk);
        #1 dma_ack = 1'b0;
        io_wr = 1'b0;
        dma_tc = 1'b0;
    endtask

    task automatic wait_rx(input int n);
        for (int t = 0; t < 3000 && u_prn.rx_q.size() < n; t++) @(posedge clk);
        `CHK(u_prn.rx_q.size(), n)
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog: the whole sequence needs a few hundred cycles
    initial begin
        #(40 * 20000);
        fails++;
        results();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 13; i++) begin
            if (rows[i][27]) wr(rows[i][26:16], rows[i][15:8]);
            else begin
                rd(rows[i][26:16], r);
                `CHK(r, rows[i][7:0])
            end
        end
        for (int i = 0; i < 8; i++) begin
            lvl = i[0];
            wr(11'h401, {2'b00, i[2:0], 3'b000});
            rd(11'h401, r);
            `CHK(r, {1'b0, i[0], i[2:0], 3'b111})
        end
        $display("register table done");
        // Bidirectional: direction turns drivers off, reads see the lines
        wr(11'h402, 8'h14);
        wr(11'h402, 8'h34);
        wr(11'h002, 8'h20);
        rd(11'h002, r);
        `CHK(r, 8'hE0)
        `CHK(pd_oe, 1'b0)
        u_prn.drv = 8'h5A;
        repeat (2) @(posedge clk); // Line levels reach the register view through two flops
        rd(11'h000, r);
        `CHK(r, 8'h5A)
        // ECP reverse with fill threshold of three
        u_prn.tx_q = '{8'h31, 8'h32, 8'h33};
        k = svc_n;
        wr(11'h402, 8'h70);
        for (int t = 0; t < 300 && svc_n == k; t++) @(posedge clk);
        `CHK(svc_n, k + 1)
        for (int i = 0; i < 3; i++) begin
            rd(11'h400, r);
            `CHK(r, 8'h31 + i[7:0])
        end
        rd(11'h402, r);
        `CHK(r, 8'h75)
        wr(11'h402, 8'h34);
        wr(11'h002, 8'h00);
        wr(11'h402, 8'h14);
        $display("reverse test done");
        // ECP forward against a stalling peripheral: fill until refused
        u_prn.dly = 20;
        wr(11'h402, 8'h74);
        wr(11'h000, 8'h81);
        for (int i = 0; i < 17; i++) wr(11'h400, 8'h10 + i[7:0]);
        rd(11'h402, r);
        `CHK(r, 8'h76)
        u_prn.dly = 1;
        wait_rx(17);
        `CHK(u_prn.rx_q[0], 9'h081)
        for (int i = 1; i < 17; i++) `CHK(u_prn.rx_q[i], {1'b1, 8'h0F + i[7:0]})
        $display("forward test done");
        k = flt_n;
        #1 fault_n = 1'b0;
        repeat (8) @(posedge clk);
        `CHK(flt_n, k)
        wr(11'h402, 8'h64);
        repeat (4) @(posedge clk);
        `CHK(flt_n, k + 1)
        #1 fault_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 fault_n = 1'b0;
        repeat (6) @(posedge clk);
        `CHK(flt_n, k + 2)
        #1 fault_n = 1'b1;
        wr(11'h402, 8'h14);
        $display("fault test done");
        // Parallel FIFO by DMA, terminal count on the last byte
        wr(11'h402, 8'h58);
        k = svc_n;
        for (int i = 0; i < 4; i++) dma(8'hC0 + i[7:0], i == 3);
        repeat (3) @(posedge clk);
        `CHK(svc_n, k + 1)
        `CHK(dma_req, 1'b0)
        wr(11'h402, 8'h50);
        repeat (4) @(posedge clk);
        `CHK(svc_n, k + 2)
        wait_rx(21);
        for (int i = 0; i < 4; i++) `CHK(u_prn.rx_q[17 + i], {1'b1, 8'hC0 + i[7:0]})
        repeat (20) @(posedge clk);
        wr(11'h402, 8'h14);
        $display("dma test done");
        // Test mode stays off the lines; standard mode empties the queue
        wr(11'h402, 8'hD4);
        for (int i = 0; i < 3; i++) wr(11'h400, 8'h70 + i[7:0]);
        for (int i = 0; i < 2; i++) begin
            rd(11'h400, r);
            `CHK(r, 8'h70 + i[7:0])
        end
        `CHK(u_prn.rx_q.size(), 21)
        wr(11'h402, 8'h14);
        wr(11'h402, 8'hD4);
        rd(11'h402, r);
        `CHK(r, 8'hD5)
        wr(11'h402, 8'h14);
        wr(11'h402, 8'h94);
        `CHK(epp_active, 1'b0)
        epp_option = 1'b1;
        #1 `CHK(epp_active, 1'b1)
        wr(11'h402, 8'h14);
        $display("mode tests done");
        // Reset in mid-run from a DMA-armed FIFO mode brings the register back
        wr(11'h402, 8'h58);
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        `CHK(dma_req, 1'b0)
        rd(11'h402, r);
        `CHK(r, 8'h15)
        $display("reset test done");
        results();
    end
endmodule
bind ecpfm_top ecpfm_asserts u_chk (.clk(clk), .rst_n(rst_n), .dma_req(dma_req), .dma_ack(dma_ack),
    .dma_tc(dma_tc), .service_irq(service_irq), .fault_irq(fault_irq), .epp_option(epp_option),
    .epp_active(epp_active), .pd_out(pd_out), .pins_in(pins_in), .pins_out(pins_out));
`default_nettype wire
